//--- core/irq_filter_pkg.sv
// constants, register map and carrier types for the external interrupt filter block
package irq_filter_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [13:0] IDX_FILTER_CTRL = 14'h3f2e;
    localparam logic [13:0] IDX_INT0_CTRL   = 14'h3fe2;
    localparam logic [13:0] IDX_INT1_CTRL   = 14'h3fe3;
    localparam logic [13:0] IDX_IRQ_STATUS  = 14'h0010;
    localparam logic [13:0] IDX_IRQ_MASK    = 14'h0011;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int NUM_CHAN        = 2;
    localparam int FC_CH0_EN       = 0;
    localparam int FC_CH0_SEL_LO   = 1;
    localparam int FC_CH1_EN       = 3;
    localparam int FC_CH1_SEL_LO   = 4;
    localparam int FC_ZC_SEL       = 7;
    localparam int IC_REQ          = 0;
    localparam int IC_IE           = 1;
    localparam int IC_EDGE         = 5;
    localparam int IC_LVL_LO       = 6;
    localparam int ST_WAKE         = 2;
    localparam int ST_BITS         = 3;

    localparam logic [7:0] FC_RW_MASK    = 8'hbf;
    localparam logic [7:0] IC_RW_MASK    = 8'he2;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // ----------------------------------------------------------------
    // sampling divisors and prescaler
    // ----------------------------------------------------------------
    localparam int PRESC_W_MIN = 9;
    localparam int DIV_SEL1    = 128;
    localparam int DIV_SEL2    = 256;
    localparam int DIV_SEL3    = 512;

    typedef enum logic [1:0] {
        SMP_FULL,
        SMP_DIV1,
        SMP_DIV2,
        SMP_DIV3
    } smp_sel_t;

    typedef struct packed {
        logic     en;
        smp_sel_t sel;
    } chan_cfg_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [13:0] idx;
    } ahb_phase_t;

endpackage : irq_filter_pkg

//--- core/noise_majority.sv
// three-sample agreement noise filter for one interrupt channel, all three samples must match
`timescale 1ns/1ps
`default_nettype none
module noise_majority
    import irq_filter_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic tick_in,
    input  wire logic en_in,
    input  wire logic din_in,
    output logic      level_out
);

    logic [1:0] hist_ff;
    logic       level_ff;
    logic       agree;

    assign agree     = (hist_ff[0] == din_in) && (hist_ff[1] == din_in);
    assign level_out = level_ff;

    // ----------------------------------------------------------------
    // sample history; frozen while disabled so re-enable resumes from the old samples
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hist_ff <= 2'h0;
        end else if (tick_in && en_in) begin
            hist_ff <= {hist_ff[0], din_in};
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            level_ff <= 1'b0;
        end else if (tick_in && en_in && agree) begin
            level_ff <= din_in;
        end
    end

    agree_update_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (tick_in && en_in && agree) |=> (level_ff == $past(din_in)))
        else $error("filter did not take three agreeing samples");

    disagree_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (tick_in && !agree) |=> $stable(level_ff))
        else $error("filter moved without three agreeing samples");

    disabled_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!en_in) |=> ($stable(level_ff) && $stable(hist_ff)))
        else $error("disabled filter changed state");

endmodule : noise_majority
`default_nettype wire

//--- core/ext_irq_noise_filter_wake.sv
// external interrupt conditioning: noise filters, zero-cross source, edges, wake, AHB-Lite regs
// Operation
// - select gives fosc, /128, /256, /512 sampling
// - enable bit set routes pin through filter
// - enable bit clear passes raw pin level
// - output follows three agreeing consecutive samples
// - disagreeing samples keep previous accepted level
// - filter idle during stop or halt
// - slow mode samples from slow clock ticks
// - edge detection acts on filtered signal
// - channel 0: bits 2-1 select, bit 0 enable
// - control bit 7 selects zero-cross for channel 1
// - zero-cross rising edge raises channel 1 request
// - standby: zero-cross high raises channel 1 request
// - standby: pin equal to edge flag wakes device
// - match at standby entry wakes immediately
// - control bit 5 selects edge, 1 rising
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_noise_filter_wake
    import irq_filter_pkg::*;
#(
    parameter int PRESC_W = 9
) (
    input  wire logic                clk_in,
    input  wire logic                arst_n_in,
    // ahb-lite slave
    input  wire logic                hsel_in,
    input  wire logic [31:0]         haddr_in,
    input  wire logic [1:0]          htrans_in,
    input  wire logic                hwrite_in,
    input  wire logic [2:0]          hsize_in,
    input  wire logic [31:0]         hwdata_in,
    input  wire logic                hready_in,
    output logic                     hreadyout_out,
    output logic [31:0]              hrdata_out,
    output logic                     hresp_out,
    // cpu mode, same clock domain
    input  wire logic                stop_in,
    input  wire logic                halt_in,
    input  wire logic                slow_in,
    input  wire logic                slow_tick_in,
    // pins, asynchronous
    input  wire logic                int_pin_a_in,
    input  wire logic                int_pin_b_in,
    input  wire logic                zero_cross_in_b_in,
    // requests
    output logic [NUM_CHAN-1:0]      int_req_out,
    output logic                     wake_out,
    output logic                     irq_out
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (PRESC_W < PRESC_W_MIN) begin : g_bad_presc
        $error("PRESC_W too narrow for the largest divisor");
    end

    localparam logic [PRESC_W-1:0] MASK1 = PRESC_W'(DIV_SEL1 - 1);
    localparam logic [PRESC_W-1:0] MASK2 = PRESC_W'(DIV_SEL2 - 1);
    localparam logic [PRESC_W-1:0] MASK3 = PRESC_W'(DIV_SEL3 - 1);

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic [7:0]          filter_ctrl_ff;
    logic [7:0]          int0_ctrl_ff;
    logic [7:0]          int1_ctrl_ff;
    logic [ST_BITS-1:0]  status_ff;
    logic [ST_BITS-1:0]  mask_ff;
    logic [PRESC_W-1:0]  presc_ff;
    logic [2:0]          pin_meta_ff;
    logic [2:0]          pin_sync_ff;
    logic [NUM_CHAN-1:0] prev_ff;
    logic                wake_ff;
    ahb_phase_t          aph_ff;

    logic                standby;
    logic                base_en;
    logic                zc_sel;
    chan_cfg_t           cfg [NUM_CHAN];
    logic [NUM_CHAN-1:0] edge_sel;
    logic [NUM_CHAN-1:0] tick;
    logic [NUM_CHAN-1:0] ch_pin;
    logic [NUM_CHAN-1:0] filt;
    logic [NUM_CHAN-1:0] src;
    logic [NUM_CHAN-1:0] rise;
    logic [NUM_CHAN-1:0] fall;
    logic [NUM_CHAN-1:0] evt;
    logic [NUM_CHAN-1:0] lvl_match;
    logic [ST_BITS-1:0]  st_set;
    logic [ST_BITS-1:0]  st_clr;
    logic [ST_BITS-1:0]  nxt_status;
    logic                wr_data;
    logic [7:0]          wbyte;
    logic [7:0]          rd_byte;

    assign standby  = stop_in || halt_in;
    assign zc_sel   = filter_ctrl_ff[FC_ZC_SEL];
    // enable sits below the select in the register but on top of the struct
    assign cfg[0]   = chan_cfg_t'({filter_ctrl_ff[FC_CH0_EN],
                                   filter_ctrl_ff[FC_CH0_SEL_LO+1:FC_CH0_SEL_LO]});
    assign cfg[1]   = chan_cfg_t'({filter_ctrl_ff[FC_CH1_EN],
                                   filter_ctrl_ff[FC_CH1_SEL_LO+1:FC_CH1_SEL_LO]});
    assign edge_sel = {int1_ctrl_ff[IC_EDGE], int0_ctrl_ff[IC_EDGE]};

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta_ff <= 3'h0;
            pin_sync_ff <= 3'h0;
        end else begin
            pin_meta_ff <= {zero_cross_in_b_in, int_pin_b_in, int_pin_a_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign ch_pin[0] = pin_sync_ff[0];
    assign ch_pin[1] = zc_sel ? pin_sync_ff[2] : pin_sync_ff[1];

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // slow mode swaps the oscillator for the slow clock ticks
    assign base_en = slow_in ? slow_tick_in : 1'b1;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            presc_ff <= '0;
        end else if (base_en) begin
            presc_ff <= presc_ff + PRESC_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // per-channel filter, path select and edge detection
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        logic div_hit;

        always_comb begin
            case (cfg[i].sel)
                SMP_FULL: div_hit = 1'b1;
                SMP_DIV1: div_hit = ((presc_ff & MASK1) == MASK1);
                SMP_DIV2: div_hit = ((presc_ff & MASK2) == MASK2);
                SMP_DIV3: div_hit = ((presc_ff & MASK3) == MASK3);
                default:  div_hit = 1'b0;
            endcase
        end

        // oscillator is down in stop and halt, so no samples are taken
        assign tick[i] = base_en && div_hit && !standby;

        noise_majority u_filt (
            .clk_in    (clk_in),
            .arst_n_in (arst_n_in),
            .tick_in   (tick[i]),
            .en_in     (cfg[i].en),
            .din_in    (ch_pin[i]),
            .level_out (filt[i])
        );

        assign src[i]  = cfg[i].en ? filt[i] : ch_pin[i];
        assign rise[i] = src[i] && !prev_ff[i];
        assign fall[i] = !src[i] && prev_ff[i];

        // standby looks at the live pin level, the filter is not running
        assign lvl_match[i] = (ch_pin[i] == edge_sel[i]);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= src;
        end
    end

    always_comb begin
        evt[0] = edge_sel[0] ? rise[0] : fall[0];
        evt[1] = edge_sel[1] ? rise[1] : fall[1];
        if (standby) begin
            evt[0] = lvl_match[0];
            evt[1] = zc_sel ? ch_pin[1] : lvl_match[1];
        end else if (zc_sel) begin
            evt[1] = rise[1];
        end
    end

    // ----------------------------------------------------------------
    // wake request
    // ----------------------------------------------------------------
    // level based, so a match already present at entry wakes at once
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= standby && (|evt);
        end
    end

    assign wake_out = wake_ff;

    // ----------------------------------------------------------------
    // ahb-lite slave: zero wait, always okay
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aph_ff <= '0;
        end else if (hready_in) begin
            aph_ff.valid <= hsel_in && htrans_in[1];
            aph_ff.write <= hwrite_in;
            aph_ff.idx   <= haddr_in[15:2];
        end
    end

    assign wr_data = aph_ff.valid && aph_ff.write;
    assign wbyte   = hwdata_in[7:0];

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            filter_ctrl_ff <= REG_RESET;
        end else if (wr_data && aph_ff.idx == IDX_FILTER_CTRL) begin
            filter_ctrl_ff <= wbyte & FC_RW_MASK;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            int0_ctrl_ff <= REG_RESET;
            int1_ctrl_ff <= REG_RESET;
        end else if (wr_data && aph_ff.idx == IDX_INT0_CTRL) begin
            int0_ctrl_ff <= wbyte & IC_RW_MASK;
        end else if (wr_data && aph_ff.idx == IDX_INT1_CTRL) begin
            int1_ctrl_ff <= wbyte & IC_RW_MASK;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_ff <= '0;
        end else if (wr_data && aph_ff.idx == IDX_IRQ_MASK) begin
            mask_ff <= wbyte[ST_BITS-1:0];
        end
    end

    // ----------------------------------------------------------------
    // sticky status, write one to clear; a new event beats the clear
    // ----------------------------------------------------------------
    assign st_set = {wake_ff, evt};
    assign st_clr = (wr_data && aph_ff.idx == IDX_IRQ_STATUS) ? wbyte[ST_BITS-1:0] : '0;
    assign nxt_status = (status_ff & ~st_clr) | st_set;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_comb begin
        case (aph_ff.idx)
            IDX_FILTER_CTRL: rd_byte = filter_ctrl_ff;
            IDX_INT0_CTRL:   rd_byte = int0_ctrl_ff | {7'h00, status_ff[0]};
            IDX_INT1_CTRL:   rd_byte = int1_ctrl_ff | {7'h00, status_ff[1]};
            IDX_IRQ_STATUS:  rd_byte = {5'h00, status_ff};
            IDX_IRQ_MASK:    rd_byte = {5'h00, mask_ff};
            default:         rd_byte = 8'h00;
        endcase
    end

    // read mux of flops; a write just before a read is seen at once
    assign hrdata_out    = (aph_ff.valid && !aph_ff.write) ? {24'h000000, rd_byte} : 32'h0;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    assign int_req_out = status_ff[NUM_CHAN-1:0] &
                         {int1_ctrl_ff[IC_IE], int0_ctrl_ff[IC_IE]};
    assign irq_out     = |(status_ff & mask_ff);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sel_div_tick_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (tick[0] && cfg[0].sel == SMP_DIV2) |-> ((presc_ff & MASK2) == MASK2))
        else $error("divided sample tick off its prescaler phase");

    filter_path_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cfg[1].en |-> (src[1] == filt[1]))
        else $error("enabled channel bypassed its filter");

    bypass_path_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!cfg[0].en) |-> (src[0] == pin_sync_ff[0]))
        else $error("disabled filter not bypassed");

    standby_freeze_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        standby |=> $stable(filt))
        else $error("filter sampled during stop or halt");

    slow_tick_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (slow_in && !slow_tick_in) |-> (tick == '0))
        else $error("slow mode sampled without a slow tick");

    edge_req_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!standby && edge_sel[0] && $rose(src[0])) |=> status_ff[0])
        else $error("rising edge of filtered level gave no request");

    ctrl_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr_data && aph_ff.idx == IDX_FILTER_CTRL)
        |=> (cfg[0] == chan_cfg_t'({$past(wbyte[FC_CH0_EN]),
                                    $past(wbyte[FC_CH0_SEL_LO+1:FC_CH0_SEL_LO])})))
        else $error("channel 0 filter config not taken from written byte");

    zc_route_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        zc_sel |-> (ch_pin[1] == pin_sync_ff[2]))
        else $error("zero-cross not routed to channel 1");

    zc_rise_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!standby && zc_sel && rise[1]) |=> status_ff[1])
        else $error("zero-cross rising edge lost");

    zc_level_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (standby && zc_sel && ch_pin[1]) |=> status_ff[1])
        else $error("standby zero-cross high gave no request");

    wake_match_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (standby && ch_pin[0] == edge_sel[0]) |=> wake_ff ##1 status_ff[ST_WAKE])
        else $error("standby level match did not wake");

    wake_entry_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ($rose(standby) && lvl_match[0]) |=> wake_out)
        else $error("match at standby entry did not wake at once");

    fall_edge_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!standby && !edge_sel[0] && fall[0]) |=> status_ff[0])
        else $error("falling edge select ignored");

    cov_filtered_edge: cover property (@(posedge clk_in) cfg[0].en && rise[0] && !standby);
    cov_zc_request: cover property (@(posedge clk_in) zc_sel && rise[1] && !standby);
    cov_wake: cover property (@(posedge clk_in) standby ##1 wake_ff);
    cov_irq: cover property (@(posedge clk_in) irq_out);

endmodule : ext_irq_noise_filter_wake
`default_nettype wire

//--- sim/irq_pin_source.sv
// outside signal source for the two interrupt pins and the zero-cross line
`timescale 1ns/1ps
`default_nettype none
module irq_pin_source (
    input  wire logic clk_in,
    output logic      pin_a_out,
    output logic      pin_b_out,
    output logic      zc_out
);
    // ----------------------------------------------------------------
    // pin levels, changed just after a clock edge
    // ----------------------------------------------------------------
    initial begin
        pin_a_out = 1'b0;
        pin_b_out = 1'b0;
        zc_out    = 1'b0;
    end

    task automatic set_pin(input int ch, input logic lvl);
        @(posedge clk_in);
        case (ch)
            0: pin_a_out <= lvl;
            1: pin_b_out <= lvl;
            default: zc_out <= lvl;
        endcase
    endtask : set_pin

    // level held for len cycles, then back
    task automatic pulse(input int ch, input logic lvl, input int len);
        set_pin(ch, lvl);
        repeat (len - 1) @(posedge clk_in);
        set_pin(ch, !lvl);
    endtask : pulse
endmodule : irq_pin_source
`default_nettype wire

//--- sim/test_ext_irq_noise_filter_wake.sv
// self-checking bench for the external interrupt filter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
end
module test_ext_irq_noise_filter_wake
    import irq_filter_pkg::*;
;
    logic              clk_in = 1'b0;
    logic              arst_n_in = 1'b0;
    logic              hsel_in = 1'b0;
    logic [31:0]       haddr_in = 32'h0;
    logic [1:0]        htrans_in = 2'h0;
    logic              hwrite_in = 1'b0;
    logic [31:0]       hwdata_in = 32'h0;
    logic              hreadyout_out;
    logic [31:0]       hrdata_out;
    logic              hresp_out;
    logic              stop_in = 1'b0;
    logic              halt_in = 1'b0;
    logic              slow_in = 1'b0;
    logic              slow_tick_in = 1'b0;
    logic              pin_a;
    logic              pin_b;
    logic              zc;
    logic [1:0]        int_req_out;
    logic              wake_out;
    logic              irq_out;
    logic              rd_phase = 1'b0;
    logic [31:0]       exp_q[$];
    logic [31:0]       exp_v;
    int                n_errors = 0;
    int                samples_checked = 0;
    int                d;

    always #10 clk_in = !clk_in;

    ext_irq_noise_filter_wake #(.PRESC_W(9)) dut_u (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out),
        .hrdata_out(hrdata_out), .hresp_out(hresp_out), .stop_in(stop_in), .halt_in(halt_in),
        .slow_in(slow_in), .slow_tick_in(slow_tick_in), .int_pin_a_in(pin_a),
        .int_pin_b_in(pin_b), .zero_cross_in_b_in(zc), .int_req_out(int_req_out),
        .wake_out(wake_out), .irq_out(irq_out));

    irq_pin_source pins_u (.clk_in(clk_in), .pin_a_out(pin_a), .pin_b_out(pin_b), .zc_out(zc));

    // ----------------------------------------------------------------
    // bus master and read-data watcher
    // ----------------------------------------------------------------
    task automatic xfer(input logic [13:0] idx, input logic wr, input logic [7:0] dat);
        @(posedge clk_in);
        hsel_in   <= 1'b1;
        haddr_in  <= {16'h0000, idx, 2'b00};
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hsel_in   <= 1'b0;
        hwdata_in <= {24'h000000, dat};
        rd_phase  <= !wr;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd_phase  <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [13:0] idx, input logic [7:0] dat);
        xfer(idx, 1'b1, dat);
    endtask : wr

    task automatic rd(input logic [13:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(idx, 1'b0, 8'h00);
    endtask : rd

    always @(posedge clk_in) begin
        if (rd_phase) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hxxxxxxxx;
            `CHK("hrdata_out", exp_v, hrdata_out)
            `CHK("hresp_out", 1'b0, hresp_out)
        end
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // whole sequence needs well under 20k cycles
    initial begin
        #1_000_000;
        n_errors++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(92));
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rd(IDX_FILTER_CTRL, 32'h0);
        rd(IDX_INT0_CTRL, 32'h0);
        rd(IDX_IRQ_STATUS, 32'h0);
        wr(14'h0123, 8'hff);
        rd(14'h0123, 32'h0);
        wr(IDX_FILTER_CTRL, 8'hff);
        rd(IDX_FILTER_CTRL, {24'h0, FC_RW_MASK});
        wr(IDX_FILTER_CTRL, 8'h00);
        wr(IDX_INT1_CTRL, 8'hff);
        rd(IDX_INT1_CTRL, {24'h0, IC_RW_MASK});
        wr(IDX_IRQ_MASK, 8'h07);
        rd(IDX_IRQ_MASK, 32'h7);
        // raw pin, both edge selections; config before clearing the flag
        for (int e = 0; e < 2; e++) begin
            wr(IDX_INT0_CTRL, 8'(8'h02 | (e << 5)));
            wr(IDX_IRQ_STATUS, 8'h07);
            pins_u.set_pin(0, !e);
            repeat (6) @(posedge clk_in);
            rd(IDX_IRQ_STATUS, 32'h0);
            pins_u.set_pin(0, e);
            repeat (6) @(posedge clk_in);
            rd(IDX_IRQ_STATUS, 32'h1);
            @(negedge clk_in);
            `CHK("irq_out", 1'b1, irq_out)
            `CHK("int_req_out", 2'b01, int_req_out)
            wr(IDX_IRQ_MASK, 8'h06);
            @(negedge clk_in);
            `CHK("irq_out", 1'b0, irq_out)
            wr(IDX_IRQ_MASK, 8'h07);
            wr(IDX_IRQ_STATUS, 8'h01);
            rd(IDX_IRQ_STATUS, 32'h0);
        end
        // filtered, every sampling select: short pulse dropped, long one passes
        pins_u.set_pin(0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            d = (s == 0) ? 1 : (s == 1) ? DIV_SEL1 : (s == 2) ? DIV_SEL2 : DIV_SEL3;
            wr(IDX_FILTER_CTRL, 8'(8'h01 | (s << 1)));
            wr(IDX_IRQ_STATUS, 8'h07);
            pins_u.pulse(0, 1'b1, 1 + ($urandom % (2 * d - 1)));
            repeat (4 * d + 8) @(posedge clk_in);
            rd(IDX_IRQ_STATUS, 32'h0);
            pins_u.pulse(0, 1'b1, 4 * d + 4);
            repeat (4 * d + 8) @(posedge clk_in);
            rd(IDX_IRQ_STATUS, 32'h1);
        end
        // slow mode: filter samples only on slow ticks
        wr(IDX_FILTER_CTRL, 8'h01);
        slow_in <= 1'b1;
        wr(IDX_IRQ_STATUS, 8'h07);
        pins_u.set_pin(0, 1'b1);
        repeat (20) @(posedge clk_in);
        rd(IDX_IRQ_STATUS, 32'h0);
        repeat (4) begin
            @(posedge clk_in);
            slow_tick_in <= 1'b1;
            @(posedge clk_in);
            slow_tick_in <= 1'b0;
        end
        repeat (6) @(posedge clk_in);
        rd(IDX_IRQ_STATUS, 32'h1);
        slow_in <= 1'b0;
        // standby wake: pin moves into match, then match already at entry
        wr(IDX_FILTER_CTRL, 8'h00);
        wr(IDX_INT0_CTRL, 8'h02);
        wr(IDX_INT1_CTRL, 8'h20);
        wr(IDX_IRQ_STATUS, 8'h07);
        stop_in <= 1'b1;
        repeat (6) @(negedge clk_in);
        `CHK("wake_out", 1'b0, wake_out)
        pins_u.set_pin(0, 1'b0);
        repeat (6) @(negedge clk_in);
        `CHK("wake_out", 1'b1, wake_out)
        @(posedge clk_in);
        stop_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        wr(IDX_IRQ_STATUS, 8'h07);
        halt_in <= 1'b1;
        repeat (4) @(negedge clk_in);
        `CHK("wake_out", 1'b1, wake_out)
        rd(IDX_IRQ_STATUS, 32'h5);
        halt_in <= 1'b0;
        // zero-cross as channel 1 source, normal then standby
        wr(IDX_INT0_CTRL, 8'h22);
        wr(IDX_INT1_CTRL, 8'h02);
        wr(IDX_FILTER_CTRL, 8'h80);
        wr(IDX_IRQ_STATUS, 8'h07);
        pins_u.pulse(1, 1'b1, 5);
        repeat (8) @(posedge clk_in);
        rd(IDX_IRQ_STATUS, 32'h0);
        pins_u.pulse(2, 1'b1, 5);
        repeat (8) @(negedge clk_in);
        `CHK("int_req_out", 2'b10, int_req_out)
        rd(IDX_IRQ_STATUS, 32'h2);
        wr(IDX_IRQ_STATUS, 8'h07);
        stop_in <= 1'b1;
        pins_u.set_pin(2, 1'b1);
        repeat (6) @(posedge clk_in);
        rd(IDX_IRQ_STATUS, 32'h6);
        stop_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        end_sim();
    end
endmodule : test_ext_irq_noise_filter_wake
`default_nettype wire
